/* rtl/itast_tracker.sv */
// transmit-abort cause tracker with avalon register slave
// Behaviour
// RL1: sixteen-bit read-only register, each bit one distinct abort reason.
// RL2: reading abort-clear or clear-all register zeroes all bits except 9.
// RL3: bit 9 clears only after restart enabled or target bits 11/10 cleared.
// RL4: clearing bit 9 while its cause remains drops it one cycle only.
// RL5: bit 9 sets on start byte attempt with restart disabled.
// RL6: bit 15 sets on command write while serving slave read request.
// RL7: bit 14 and bit 12 set together on slave SDA mismatch at SCL rise.
// RL8: bit 13 sets on slave read command with data left in TX FIFO.
// RL9: bit 12 sets on master arbitration loss or slave transmitter loss.
// RL10: bit 11 sets on master start attempt while master mode disabled.
// RL11: bit 10 sets on 10-bit read command with restart disabled.
// RL12: bit 8 sets on high speed master transfer with restart disabled.
// RL13: bit 7 sets when a sent START byte is acknowledged.
// RL14: bit 6 sets when the high speed master code is acknowledged.
// RL15: bit 5 sets when general call is followed by a programmed read.
// RL16: bit 4 sets when no slave acknowledges a general call.
// RL17: bit 3 sets in master mode when a data byte is not acknowledged.
// RL18: bit 2 sets when second 10-bit address byte is not acknowledged.
// RL19: bit 1 sets when first 10-bit address byte is not acknowledged.
// RL20: bit 0 sets when a 7-bit address is not acknowledged.
// RL21: any set cause raises transmit abort and holds the transfer stopped.
module itast_tracker #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic      [1:0]        avs_response_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire logic              mst_active_i,
  input  wire logic              mst_start_req_i,
  input  wire logic              mst_hs_mode_i,
  input  wire logic              mst_sbyte_ack_i,
  input  wire logic              mst_hs_code_ack_i,
  input  wire logic              mst_gcall_sent_i,
  input  wire logic              mst_gcall_nack_i,
  input  wire logic              mst_data_nack_i,
  input  wire logic              mst_addr_nack_i,
  input  wire logic              mst_addr_second_i,
  input  wire logic              mst_arb_loss_i,
  input  wire logic              slv_rd_req_i,
  input  wire logic              slv_rd_cmd_i,
  input  wire logic              slv_tx_active_i,
  input  wire logic              slv_tx_bit_i,
  input  wire logic              tx_fifo_empty_i,
  output logic                   dc_wr_o,
  output logic      [9:0]        dc_data_o,
  output logic      [15:0]       abort_cause_o,
  output logic                   transmit_abort_flag_o
);

  // refuse address widths that cannot reach the map
  if (ADDR_W < 8)
  begin : g_chk
    $error("itast_tracker: ADDR_W must be at least 8");
  end

  itast_pkg::itast_bus_t bus_q;
  itast_pkg::itast_bus_t next_bus;
  logic [15:0]           control_reg;
  logic [15:0]           target_address_reg;
  logic [9:0]            data_command_reg;
  logic [15:0]           abort_cause_status;
  logic [15:0]           cause_set;
  logic                  sbyte_clr_d;
  logic [1:0]            pins_s;
  logic                  scl_d;

  // bus decode
  wire        req        = avs_read_i | avs_write_i;
  wire        first_cyc  = req && (bus_q == itast_pkg::BUS_IDLE);
  wire        accept     = req && (bus_q == itast_pkg::BUS_ANSWER);
  wire [7:0]  adr        = avs_address_i[7:0];
  wire        adr_hi_ok  = (avs_address_i >> 8) == '0;
  wire        hit_ctl    = adr_hi_ok && adr == itast_pkg::OFS_CONTROL;
  wire        hit_tar    = adr_hi_ok && adr == itast_pkg::OFS_TARGET;
  wire        hit_dc     = adr_hi_ok && adr == itast_pkg::OFS_DATA_CMD;
  wire        hit_allclr = adr_hi_ok && adr == itast_pkg::OFS_ALL_IRQ_CLR;
  wire        hit_abclr  = adr_hi_ok && adr == itast_pkg::OFS_ABORT_CLR;
  wire        hit_cause  = adr_hi_ok && adr == itast_pkg::OFS_ABORT_CAUSE;
  wire        hit_any    = hit_ctl | hit_tar | hit_dc | hit_allclr
                           | hit_abclr | hit_cause;
  wire [15:0] be_mask    = {{8{avs_byteenable_i[1]}},
                            {8{avs_byteenable_i[0]}}};
  wire [15:0] wdata      = avs_writedata_i[15:0];
  wire        wr_acc     = accept && avs_write_i;
  wire        rd_acc     = accept && avs_read_i;
  wire        dc_wr_acc  = wr_acc && hit_dc && avs_byteenable_i[1:0] != 2'h0;

  // waitrequest is combinational: one wait state on every access
  assign avs_waitrequest_o = first_cyc;

  // answer phase walks idle -> answer -> idle
  always_comb
  begin
    next_bus = bus_q;
    case (bus_q)
      itast_pkg::BUS_IDLE:   if (req) next_bus = itast_pkg::BUS_ANSWER;
      itast_pkg::BUS_ANSWER: next_bus = itast_pkg::BUS_IDLE;
      default:               next_bus = itast_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_q <= itast_pkg::BUS_IDLE;
    else
      bus_q <= next_bus;
  end

  // read mux; clear registers read as zero, cause bits above 15 as zero
  wire [15:0] rd_mux =
    hit_ctl   ? control_reg :
    hit_tar   ? target_address_reg :
    hit_dc    ? {6'h00, data_command_reg} :
    hit_cause ? abort_cause_status : 16'h0000; // RL1

  // read data captured in the wait cycle so it stands at the accept edge
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= itast_pkg::RESP_OKAY;
    end
    else if (first_cyc)
    begin
      avs_readdata_o <= {16'h0000, rd_mux};
      avs_response_o <= hit_any ? itast_pkg::RESP_OKAY
                                : itast_pkg::RESP_SLVERR;
    end
  end

  // software-owned configuration; writes land at the accept edge
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      control_reg        <= itast_pkg::CONTROL_RST;
      target_address_reg <= itast_pkg::TARGET_RST;
    end
    else if (wr_acc)
    begin
      if (hit_ctl)
        control_reg <= (control_reg & ~be_mask) | (wdata & be_mask);
      if (hit_tar)
        target_address_reg <= (target_address_reg & ~be_mask)
                              | (wdata & be_mask);
    end
  end

  // command writes pass on to the transmit path as a one-cycle strobe
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_command_reg <= itast_pkg::DATA_CMD_RST;
      dc_wr_o          <= 1'b0;
    end
    else
    begin
      dc_wr_o <= dc_wr_acc;
      if (dc_wr_acc)
        data_command_reg <= wdata[itast_pkg::DC_W-1:0];
    end
  end
  assign dc_data_o = data_command_reg;

  // config terms
  wire restart_en = control_reg[itast_pkg::CTL_RESTART_EN];
  wire master_en  = control_reg[itast_pkg::CTL_MASTER_EN];
  wire tenbit     = target_address_reg[itast_pkg::TAR_TENBIT];
  wire alt_addr_select          = target_address_reg[itast_pkg::TAR_ALT_SEL];
  wire gencall_or_startbyte_sel = target_address_reg[itast_pkg::TAR_GCOS_SEL];
  // level that keeps the start byte cause alive until software fixes it
  wire sbyte_cause = !restart_en && alt_addr_select
                     && gencall_or_startbyte_sel; // RL3
  wire dc_cmd_wr   = dc_wr_acc && wdata[itast_pkg::DC_CMD];

  // pins come from the bus wires: two flops before any logic reads them
  itast_sync #(
    .W (2)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({~scl_i, ~sda_i}),
    .q_o     (pins_s)
  );
  // pins pass inverted so the zero reset of the sync is the idle-high bus
  wire scl_s = !pins_s[1];
  wire sda_s = !pins_s[0];

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      scl_d <= 1'b1;
    else
      scl_d <= scl_s;
  end

  // slave only ever releases the line, so a mismatch means someone else won
  wire scl_rise  = scl_s && !scl_d;
  wire slv_loss  = scl_rise && slv_tx_active_i
                   && (sda_s != slv_tx_bit_i); // RL7

  // remember a clear of bit 9 so the live cause can re-raise it next cycle
  wire cause_clr = rd_acc && (hit_abclr || hit_allclr); // RL2
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sbyte_clr_d <= 1'b0;
    else
      sbyte_clr_d <= cause_clr; // RL4
  end

  // set terms for each cause bit
  assign cause_set[itast_pkg::CB_7B_NACK]     = mst_addr_nack_i
                                                && !tenbit; // RL20
  assign cause_set[itast_pkg::CB_10B1_NACK]   = mst_addr_nack_i && tenbit
                                                && !mst_addr_second_i; // RL19
  assign cause_set[itast_pkg::CB_10B2_NACK]   = mst_addr_nack_i && tenbit
                                                && mst_addr_second_i; // RL18
  assign cause_set[itast_pkg::CB_DATA_NACK]   = mst_data_nack_i
                                                && mst_active_i; // RL17
  assign cause_set[itast_pkg::CB_GCALL_NACK]  = mst_gcall_nack_i; // RL16
  assign cause_set[itast_pkg::CB_GCALL_READ]  = mst_gcall_sent_i
      && data_command_reg[itast_pkg::DC_GCALL_RD]; // RL15
  assign cause_set[itast_pkg::CB_HS_ACKED]    = mst_hs_code_ack_i; // RL14
  assign cause_set[itast_pkg::CB_SBYTE_ACKED] = mst_sbyte_ack_i; // RL13
  assign cause_set[itast_pkg::CB_HS_NORS]     = mst_start_req_i
      && mst_hs_mode_i && !restart_en; // RL12
  assign cause_set[itast_pkg::CB_SBYTE_NORS]  = (mst_start_req_i
      && sbyte_cause) || (sbyte_clr_d && sbyte_cause); // RL5 RL4
  assign cause_set[itast_pkg::CB_10B_RD_NORS] = dc_cmd_wr && tenbit
      && !restart_en; // RL11
  assign cause_set[itast_pkg::CB_MST_DIS]     = mst_start_req_i
      && !master_en; // RL10
  assign cause_set[itast_pkg::CB_ARB_LOSS]    = mst_arb_loss_i
      || slv_loss; // RL9
  assign cause_set[itast_pkg::CB_SLV_FLUSH]   = slv_rd_cmd_i
      && !tx_fifo_empty_i; // RL8
  assign cause_set[itast_pkg::CB_SLV_LOSS]    = slv_loss; // RL7
  assign cause_set[itast_pkg::CB_SLV_RD_CMD]  = dc_cmd_wr
      && slv_rd_req_i; // RL6

  // one sticky cell per cause; set wins over a simultaneous clear
  for (genvar b = 0; b < itast_pkg::REG_W; b++)
  begin : g_cause
    itast_cause_bit u_bit (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .set_i   (cause_set[b]),
      .clr_i   (cause_clr), // RL2
      .q_o     (abort_cause_status[b])
    );
  end

  // abort holds the transfer stopped while any cause stands
  assign abort_cause_o         = abort_cause_status;
  assign transmit_abort_flag_o = |abort_cause_status; // RL21

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_clear_live;
    cause_clr && sbyte_cause && !mst_start_req_i;
  endsequence
  sequence s_drop_back;
    !abort_cause_status[9] ##1 abort_cause_status[9];
  endsequence

  a_bit9_reassert : assert property ( // RL4
    s_clear_live |=> s_drop_back)
    else $error("bit 9 did not drop one cycle and return");

  a_clear_rest : assert property ( // RL2
    (cause_clr && cause_set == 16'h0000) |=>
      (abort_cause_status & 16'hfdff) == 16'h0000)
    else $error("cause bits survived a clear read");

  a_bus_wait : assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");

  a_slave_pair : assert property ( // RL7
    $rose(abort_cause_status[14]) |-> abort_cause_status[12])
    else $error("bit 14 rose without bit 12");

  a_master_dis : assert property ( // RL10
    (mst_start_req_i && !master_en) |=> abort_cause_status[11])
    else $error("master disabled attempt not recorded");

  a_flush_stale : assert property ( // RL8
    (slv_rd_cmd_i && !tx_fifo_empty_i) |=> abort_cause_status[13])
    else $error("stale data flush not recorded");

  a_abort_flag : assert property ( // RL21
    (cause_set != 16'h0000) |=> transmit_abort_flag_o)
    else $error("abort flag low with a cause set");

  a_seven_nack : assert property ( // RL20
    (mst_addr_nack_i && !tenbit && !cause_clr) |=>
      abort_cause_status[0] ##1 (abort_cause_status[0] || $past(cause_clr)))
    else $error("7-bit address nack not held");

  a_hs_norestart : assert property ( // RL12
    (mst_start_req_i && mst_hs_mode_i && !restart_en) |=>
      abort_cause_status[8])
    else $error("high speed without restart not recorded");

  a_read_only : assert property ( // RL1
    (wr_acc && hit_cause && cause_set == 16'h0000 && !cause_clr) |=>
      $stable(abort_cause_status))
    else $error("write altered the cause register");

  a_dc_strobe : assert property (
    dc_wr_o |=> !dc_wr_o)
    else $error("command strobe longer than one cycle");

  a_gcall_read : assert property ( // RL15
    (mst_gcall_sent_i && data_command_reg[itast_pkg::DC_GCALL_RD]) |=>
      abort_cause_status[itast_pkg::CB_GCALL_READ])
    else $error("general call read not recorded");

  a_tenbit_read : assert property ( // RL11
    (dc_cmd_wr && tenbit && !restart_en) |=>
      abort_cause_status[itast_pkg::CB_10B_RD_NORS])
    else $error("10-bit read without restart not recorded");

  a_slave_cmd : assert property ( // RL6
    (dc_cmd_wr && slv_rd_req_i) |=>
      abort_cause_status[itast_pkg::CB_SLV_RD_CMD])
    else $error("command write in slave read not recorded");

  a_arb_loss : assert property ( // RL9
    mst_arb_loss_i |=> abort_cause_status[itast_pkg::CB_ARB_LOSS])
    else $error("arbitration loss not recorded");

endmodule

/* rtl/itast_pkg.sv */
// constants shared by the transmit-abort cause tracker
package itast_pkg;

  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_CONTROL     = 8'h00;
  localparam logic [7:0] OFS_TARGET      = 8'h04;
  localparam logic [7:0] OFS_DATA_CMD    = 8'h10;
  localparam logic [7:0] OFS_ALL_IRQ_CLR = 8'h40;
  localparam logic [7:0] OFS_ABORT_CLR   = 8'h54;
  localparam logic [7:0] OFS_ABORT_CAUSE = 8'h80;

  // register width and reset values
  localparam int         REG_W           = 16;
  localparam logic [15:0] CONTROL_RST    = 16'h0021;
  localparam logic [15:0] TARGET_RST     = 16'h0000;
  localparam logic [15:0] CAUSE_RST      = 16'h0000;
  localparam logic [9:0]  DATA_CMD_RST   = 10'h000;

  // control_reg fields
  localparam int CTL_MASTER_EN  = 0;
  localparam int CTL_RESTART_EN = 5;
  // target_address_reg fields
  localparam int TAR_GCOS_SEL   = 10;
  localparam int TAR_ALT_SEL    = 11;
  localparam int TAR_TENBIT     = 12;
  // data_command_reg fields
  localparam int DC_W           = 10;
  localparam int DC_CMD         = 8;
  localparam int DC_GCALL_RD    = 9;

  // abort_cause_status bit positions
  localparam int CB_7B_NACK     = 0;
  localparam int CB_10B1_NACK   = 1;
  localparam int CB_10B2_NACK   = 2;
  localparam int CB_DATA_NACK   = 3;
  localparam int CB_GCALL_NACK  = 4;
  localparam int CB_GCALL_READ  = 5;
  localparam int CB_HS_ACKED    = 6;
  localparam int CB_SBYTE_ACKED = 7;
  localparam int CB_HS_NORS     = 8;
  localparam int CB_SBYTE_NORS  = 9;
  localparam int CB_10B_RD_NORS = 10;
  localparam int CB_MST_DIS     = 11;
  localparam int CB_ARB_LOSS    = 12;
  localparam int CB_SLV_LOSS    = 13 + 1;
  localparam int CB_SLV_FLUSH   = 13;
  localparam int CB_SLV_RD_CMD  = 15;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus answer phase
  typedef enum logic { BUS_IDLE, BUS_ANSWER } itast_bus_t;

endpackage

/* rtl/itast_sync.sv */
// two-flop synchroniser for pin levels
module itast_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* rtl/itast_cause_bit.sv */
// one sticky abort cause bit, set wins over clear
module itast_cause_bit (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      q_o
);
  // a cause seen in the clearing cycle must not be lost
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
    else if (clr_i)
      q_o <= 1'b0;
  end
endmodule

/* dv/itast_remote_dev.sv */
// remote bus device: clocks scl within frames, pulls sda on demand
module itast_remote_dev (
  input  wire logic frame_i,
  input  wire logic sda_low_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // scl only runs inside a frame; the pull-up holds it high between
  always
  begin
    if (frame_i)
    begin
      scl_o = 1'b0;
      #32;
      scl_o = 1'b1;
      #32;
    end
    else
    begin
      scl_o = 1'b1;
      wait (frame_i);
    end
  end

  // open drain: a released line reads high through the pull-up
  assign sda_o = sda_low_i ? 1'b0 : 1'b1;
endmodule

/* dv/itast_tracker_tb.sv */
// self-checking bench for the transmit-abort cause tracker
module itast_tracker_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i;
  logic        rst_n_i;
  logic [7:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic        wait_r;
  logic        scl;
  logic        sda;
  logic        frame;
  logic        sda_low;
  logic [8:0]  ev;
  logic [6:0]  lv;
  logic        dc_wr;
  logic [9:0]  dc_data;
  logic [15:0] cause;
  logic        abort;
  logic [31:0] q;
  logic [1:0]  r;
  logic [7:0]  clr;
  int          n_fail;
  int          total_checks;

  itast_tracker itast_tracker_inst (
    .mclk_i                (mclk_i),
    .rst_n_i               (rst_n_i),
    .avs_address_i         (adr),
    .avs_read_i            (rd),
    .avs_write_i           (wr),
    .avs_writedata_i       (wdat),
    .avs_byteenable_i      (4'hf),
    .avs_readdata_o        (rdat),
    .avs_response_o        (resp),
    .avs_waitrequest_o     (wait_r),
    .scl_i                 (scl),
    .sda_i                 (sda),
    .mst_active_i          (lv[0]),
    .mst_start_req_i       (ev[0]),
    .mst_hs_mode_i         (lv[1]),
    .mst_sbyte_ack_i       (ev[1]),
    .mst_hs_code_ack_i     (ev[2]),
    .mst_gcall_sent_i      (ev[3]),
    .mst_gcall_nack_i      (ev[4]),
    .mst_data_nack_i       (ev[5]),
    .mst_addr_nack_i       (ev[6]),
    .mst_addr_second_i     (lv[2]),
    .mst_arb_loss_i        (ev[7]),
    .slv_rd_req_i          (lv[3]),
    .slv_rd_cmd_i          (ev[8]),
    .slv_tx_active_i       (lv[4]),
    .slv_tx_bit_i          (lv[5]),
    .tx_fifo_empty_i       (lv[6]),
    .dc_wr_o               (dc_wr),
    .dc_data_o             (dc_data),
    .abort_cause_o         (cause),
    .transmit_abort_flag_o (abort)
  );

  itast_remote_dev itast_remote_dev_inst (
    .frame_i   (frame),
    .sda_low_i (sda_low),
    .scl_o     (scl),
    .sda_o     (sda)
  );

  // 200 MHz system clock
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr  <= a;
    wr   <= w;
    rd   <= ~w;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (wait_r !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      n_fail++;
      $display("Error at %0t: bus hang", $time);
      end_of_test();
    end
    q = rdat;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e,
                       input logic [1:0] er);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
    chk({30'h0, r}, {30'h0, er});
  endtask

  // set one cause, read it, undo the cause, clear, read zero
  task automatic cc(input logic [15:0] ctl, input logic [15:0] tar,
                    input logic [6:0] l, input int e,
                    input logic [9:0] dcw, input logic [15:0] exp);
    bus(1'b1, itast_pkg::OFS_CONTROL, ctl);
    bus(1'b1, itast_pkg::OFS_TARGET, tar);
    lv <= l;
    if (dcw !== 10'h000)
    begin
      bus(1'b1, itast_pkg::OFS_DATA_CMD, {6'h00, dcw});
      #1;
      chk({31'h0, dc_wr}, 32'h1);
      chk({22'h0, dc_data}, {22'h0, dcw});
    end
    if (e >= 0)
    begin
      @(posedge mclk_i);
      ev <= 9'h001 << e;
      @(posedge mclk_i);
      ev <= 9'h000;
    end
    rdchk(itast_pkg::OFS_ABORT_CAUSE, exp, itast_pkg::RESP_OKAY);
    chk({31'h0, abort}, {31'h0, |exp});
    bus(1'b1, itast_pkg::OFS_CONTROL, 16'h0021);
    bus(1'b1, itast_pkg::OFS_TARGET, 16'h0000);
    lv  <= 7'h60;
    clr = (clr == itast_pkg::OFS_ABORT_CLR) ? itast_pkg::OFS_ALL_IRQ_CLR
                                            : itast_pkg::OFS_ABORT_CLR;
    rdchk(clr, 16'h0000, itast_pkg::RESP_OKAY);
    rdchk(itast_pkg::OFS_ABORT_CAUSE, 16'h0000, itast_pkg::RESP_OKAY);
    chk({31'h0, abort}, 32'h0);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: the tests need well under 20 us
  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    rst_n_i = 1'b0;
    adr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    ev = 9'h000;
    lv = 7'h60;
    frame = 1'b0;
    sda_low = 1'b0;
    clr = itast_pkg::OFS_ALL_IRQ_CLR;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdchk(itast_pkg::OFS_ABORT_CAUSE, 16'h0000, itast_pkg::RESP_OKAY);
    bus(1'b1, itast_pkg::OFS_ABORT_CAUSE, 16'hffff);
    rdchk(itast_pkg::OFS_ABORT_CAUSE, 16'h0000, itast_pkg::RESP_OKAY);
    rdchk(8'h20, 16'h0000, itast_pkg::RESP_SLVERR);
    cc(16'h0021, 16'h0000, 7'h60, 6, 10'h000, 16'h0001);
    cc(16'h0021, 16'h1000, 7'h60, 6, 10'h000, 16'h0002);
    cc(16'h0021, 16'h1000, 7'h64, 6, 10'h000, 16'h0004);
    cc(16'h0021, 16'h0000, 7'h61, 5, 10'h000, 16'h0008);
    cc(16'h0021, 16'h0000, 7'h60, 5, 10'h000, 16'h0000);
    cc(16'h0021, 16'h0000, 7'h60, 4, 10'h000, 16'h0010);
    cc(16'h0021, 16'h0000, 7'h60, 3, 10'h200, 16'h0020);
    cc(16'h0021, 16'h0000, 7'h62, 2, 10'h000, 16'h0040);
    cc(16'h0021, 16'h0000, 7'h60, 1, 10'h000, 16'h0080);
    cc(16'h0001, 16'h0000, 7'h62, 0, 10'h000, 16'h0100);
    cc(16'h0001, 16'h0c00, 7'h60, 0, 10'h000, 16'h0200);
    cc(16'h0001, 16'h1000, 7'h60, -1, 10'h100, 16'h0400);
    cc(16'h0020, 16'h0000, 7'h60, 0, 10'h000, 16'h0800);
    cc(16'h0021, 16'h0000, 7'h60, 0, 10'h000, 16'h0000);
    cc(16'h0021, 16'h0000, 7'h60, 7, 10'h000, 16'h1000);
    cc(16'h0021, 16'h0000, 7'h20, 8, 10'h000, 16'h2000);
    cc(16'h0021, 16'h0000, 7'h60, 8, 10'h000, 16'h0000);
    cc(16'h0021, 16'h0000, 7'h68, -1, 10'h100, 16'h8000);
    // clear while the start-byte cause persists: one-cycle drop
    bus(1'b1, itast_pkg::OFS_CONTROL, 16'h0001);
    bus(1'b1, itast_pkg::OFS_TARGET, 16'h0c00);
    @(posedge mclk_i);
    ev[0] <= 1'b1;
    @(posedge mclk_i);
    ev <= 9'h000;
    bus(1'b0, itast_pkg::OFS_ABORT_CLR, 16'h0000);
    #1;
    chk({31'h0, cause[9]}, 32'h0);
    @(posedge mclk_i);
    #1;
    chk({31'h0, cause[9]}, 32'h1);
    rdchk(itast_pkg::OFS_ABORT_CAUSE, 16'h0200, itast_pkg::RESP_OKAY);
    cc(16'h0021, 16'h0000, 7'h60, -1, 10'h000, 16'h0200);
    // slave drives 0 then released 1 against a low sda
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk_i);
      lv      <= (i == 0) ? 7'h50 : 7'h70;
      sda_low <= 1'b1;
      frame   <= 1'b1;
      repeat (60) @(posedge mclk_i);
      frame   <= 1'b0;
      lv      <= 7'h60;
      sda_low <= 1'b0;
      rdchk(itast_pkg::OFS_ABORT_CAUSE, (i == 0) ? 16'h0000 : 16'h5000,
            itast_pkg::RESP_OKAY);
      rdchk(itast_pkg::OFS_ALL_IRQ_CLR, 16'h0000, itast_pkg::RESP_OKAY);
    end
    rdchk(itast_pkg::OFS_ABORT_CAUSE, 16'h0000, itast_pkg::RESP_OKAY);
    end_of_test();
  end
endmodule
